// ==== rtl/pulse_train_arc_and_table_output.sv ====
// Two-channel pulse train generator: absolute arc and table output
`timescale 1ns/1ps
`include "pulse_train_defs.svh"

module pulse_train_arc_and_table_output
    import pulse_train_pkg::*;
#(
    parameter int SEG_WORDS = 160
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Drive pins
    output logic x_pulse_out,
    output logic x_direction_out,
    output logic y_pulse_out,
    output logic y_direction_out,
    output logic first_channel_done_flag
);

    pulse_state_t s;
    pulse_state_t next_s;
    logic [15:0] table_mem [0:SEG_WORDS-1];
    logic [7:0] word;
    logic req;
    logic hit;
    logic in_table;
    logic [7:0] tidx;
    logic [1:0] fall;

    assign word = address[9:2];
    assign req = read | write;
    assign hit = req & ~s.bus_wait;
    assign in_table = (word >= `OFS_TABLE) &&
        (word < `OFS_TABLE + 8'(SEG_WORDS));
    assign tidx = word - `OFS_TABLE;

    function automatic logic [16:0] clamp_freq(input logic [31:0] f);
        if (f < 32'(`FREQ_MIN_HZ))
            return `FREQ_MIN_HZ;
        else if (f > 32'(`FREQ_MAX_HZ))
            return `FREQ_MAX_HZ;
        else
            return f[16:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        logic [16:0] f;
        logic [28:0] sum;
        logic run;
        logic adv;
        logic ld;
        logic [5:0] ld_seg;
        logic [7:0] b;
        f = '0;
        sum = '0;
        run = 1'b0;
        adv = 1'b0;
        ld = 1'b0;
        ld_seg = 6'h01;
        b = '0;
        next_s = s;
        fall = 2'b00;

        // One wait cycle, then the answer; read data loaded meanwhile
        next_s.bus_wait = ~(req & s.bus_wait);
        if (req && s.bus_wait)
        begin
            next_s.rdata = 32'h0000_0000;
            case (word)
                `OFS_CTRL: next_s.rdata = {28'h0, s.tab_chan, s.cyclic,
                    s.tab_run, s.arc_run};
                `OFS_STATUS: next_s.rdata = {18'h0, s.seg_cur, 5'h0,
                    s.arc_act, s.tab_act, s.done};
                `OFS_POS0_LO: next_s.rdata = {16'h0, s.pos[0][15:0]};
                `OFS_POS0_HI: next_s.rdata = {16'h0, s.pos[0][31:16]};
                `OFS_POS1_LO: next_s.rdata = {16'h0, s.pos[1][15:0]};
                `OFS_POS1_HI: next_s.rdata = {16'h0, s.pos[1][31:16]};
                `OFS_TGT_X: next_s.rdata = s.tgt[0];
                `OFS_TGT_Y: next_s.rdata = s.tgt[1];
                `OFS_ARC_FREQ: next_s.rdata = s.arc_freq;
                `OFS_SEG_COUNT: next_s.rdata = {26'h0, s.seg_count};
                default:
                    if (in_table)
                        next_s.rdata = {16'h0, table_mem[tidx]};
            endcase
        end
        if (write && hit)
        begin
            case (word)
                `OFS_CTRL:
                begin
                    next_s.arc_run = writedata[`CTRL_ARC_RUN];
                    next_s.tab_run = writedata[`CTRL_TAB_RUN];
                    next_s.cyclic = writedata[`CTRL_CYCLIC];
                    if (!s.tab_act)
                        next_s.tab_chan = writedata[`CTRL_TAB_CHAN];
                end
                `OFS_STATUS:
                    if (writedata[`STAT_DONE])
                        next_s.done = 1'b0;
                `OFS_POS0_LO: next_s.pos[0][15:0] = writedata[15:0];
                `OFS_POS0_HI: next_s.pos[0][31:16] = writedata[15:0];
                `OFS_POS1_LO: next_s.pos[1][15:0] = writedata[15:0];
                `OFS_POS1_HI: next_s.pos[1][31:16] = writedata[15:0];
                `OFS_TGT_X: next_s.tgt[0] = writedata;
                `OFS_TGT_Y: next_s.tgt[1] = writedata;
                `OFS_ARC_FREQ: next_s.arc_freq = writedata;
                `OFS_SEG_COUNT: next_s.seg_count = writedata[5:0];
                default: ;
            endcase
        end

        // Pulse engines; every falling half counts, a cut one too
        for (int c = 0; c < 2; c++)
        begin
            run = 1'b0;
            f = '0;
            if (s.arc_act && s.arc_run && s.pos[c] != s.tgt[c])
            begin
                run = 1'b1;
                f = clamp_freq(s.arc_freq);
            end
            else if (s.tab_act && s.tab_run && s.tab_chan == c[0])
            begin
                run = 1'b1;
                f = s.tab_freq;
            end
            if (!run)
            begin
                next_s.acc[c] = '0;
                next_s.lvl[c] = 1'b0;
                fall[c] = s.lvl[c];
            end
            else
            begin
                sum = s.acc[c] + {11'h0, f, 1'b0};
                if (sum >= `CLOCK_HZ)
                begin
                    next_s.acc[c] = sum - `CLOCK_HZ;
                    next_s.lvl[c] = ~s.lvl[c];
                    fall[c] = s.lvl[c];
                end
                else
                    next_s.acc[c] = sum;
            end
            if (fall[c])
            begin
                if (s.dir[c])
                    next_s.pos[c] = s.pos[c] - 32'h0000_0001;
                else
                    next_s.pos[c] = s.pos[c] + 32'h0000_0001;
            end
        end

        // Absolute arc: one pulse/direction pair per axis
        if (!s.arc_run)
        begin
            next_s.arc_act = 1'b0;
            next_s.arc_fin = 1'b0;
            next_s.dir = 2'b00;
        end
        else if (!s.arc_act && !s.arc_fin && !s.tab_act)
        begin
            next_s.arc_act = 1'b1;
            for (int c = 0; c < 2; c++)
                next_s.dir[c] = $signed(s.tgt[c]) < $signed(s.pos[c]);
        end
        else if (s.arc_act && s.pos[0] == s.tgt[0] &&
            s.pos[1] == s.tgt[1] && s.lvl == 2'b00)
        begin
            next_s.arc_act = 1'b0;
            next_s.arc_fin = 1'b1;
            next_s.done = 1'b1;
        end

        // Table output: pulses only, direction left alone
        if (!s.tab_run)
        begin
            next_s.tab_act = 1'b0;
            next_s.tab_fin = 1'b0;
        end
        else if (!s.tab_act && !s.tab_fin && !next_s.arc_act)
        begin
            ld = 1'b1;
            ld_seg = 6'h01;
            next_s.seg_cap = (s.seg_count == 6'h00) ? 6'h01 :
                (s.seg_count > `SEG_MAX) ? `SEG_MAX : s.seg_count;
            next_s.tab_act = 1'b1;
        end
        else if (s.tab_act)
        begin
            adv = (s.tab_left == 32'h0) ||
                (fall[s.tab_chan] && s.tab_left == 32'h1);
            if (fall[s.tab_chan])
                next_s.tab_left = s.tab_left - 32'h0000_0001;
            if (adv)
            begin
                if (s.seg_cur < s.seg_cap)
                begin
                    ld = 1'b1;
                    ld_seg = s.seg_cur + 6'h01;
                end
                else if (s.cyclic)
                begin
                    ld = 1'b1;
                    ld_seg = 6'h01;
                end
                else
                begin
                    next_s.tab_act = 1'b0;
                    next_s.tab_fin = 1'b1;
                    if (!s.tab_chan)
                        next_s.done = 1'b1;
                end
            end
        end
        if (ld)
        begin
            b = 8'((ld_seg - 6'h01) * `WORDS_PER_SEG);
            next_s.seg_cur = ld_seg;
            next_s.tab_freq = clamp_freq({table_mem[b + 8'h01],
                table_mem[b]});
            next_s.tab_left = {table_mem[b + 8'h03], table_mem[b + 8'h02]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            s <= '0;
            s.bus_wait <= 1'b1;
            s.arc_freq <= `ARC_FREQ_RESET;
            s.seg_count <= `SEG_COUNT_RESET;
            s.seg_cap <= `SEG_COUNT_RESET;
        end
        else
            s <= next_s;
    end

    // Segment table; writes refused while a table is running
    always_ff @(posedge clock)
    begin
        if (write && hit && in_table && !s.tab_act)
            table_mem[tidx] <= writedata[15:0];
    end

    assign readdata = s.rdata;
    assign waitrequest = s.bus_wait;
    assign x_pulse_out = s.lvl[0];
    assign y_pulse_out = s.lvl[1];
    assign x_direction_out = s.dir[0];
    assign y_direction_out = s.dir[1];
    assign first_channel_done_flag = s.done;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence arc_start_s;
        s.arc_run && !s.arc_act && !s.arc_fin && !s.tab_act;
    endsequence
    sequence arc_end_s;
        s.arc_act && s.arc_run && s.pos[0] == s.tgt[0] &&
            s.pos[1] == s.tgt[1] && s.lvl == 2'b00;
    endsequence

    dir_positive_a: assert property (arc_start_s and
        ($signed(s.tgt[0]) >= $signed(s.pos[0])) |=> !x_direction_out)
        else $error("x direction not off for positive move");
    dir_negative_a: assert property (arc_start_s and
        ($signed(s.tgt[1]) < $signed(s.pos[1])) |=> y_direction_out)
        else $error("y direction not on for negative move");
    arc_done_a: assert property (arc_end_s |=>
        first_channel_done_flag && !s.arc_act)
        else $error("done flag missing at arc end");
    dir_hold_a: assert property ((s.arc_fin && s.arc_run) ##1 s.arc_run
        |-> $stable(s.dir))
        else $error("direction moved after arc end");
    dir_clear_a: assert property (!s.arc_run |=> s.dir == 2'b00)
        else $error("direction not cleared after drive off");
    pos_step_a: assert property ((s.lvl[0] && !next_s.lvl[0] &&
        !s.dir[0] && !(write && hit)) |=> s.pos[0] == $past(s.pos[0]) + 1)
        else $error("position did not advance by one");
    table_stop_a: assert property ((!s.tab_run && !s.arc_act)
        |=> !x_pulse_out && !y_pulse_out)
        else $error("pulse kept running after disable");
    freq_span_a: assert property (s.tab_act |->
        s.tab_freq >= `FREQ_MIN_HZ && s.tab_freq <= `FREQ_MAX_HZ)
        else $error("segment frequency out of span");
    cyclic_wrap_a: assert property ((s.tab_act && s.tab_run &&
        s.cyclic && s.seg_cur == s.seg_cap && (s.tab_left == 32'h0 ||
        (fall[s.tab_chan] && s.tab_left == 32'h1)))
        |=> s.seg_cur == 6'h01 && s.tab_act)
        else $error("cyclic table did not restart");
    seg_limit_a: assert property (s.tab_act |->
        s.seg_cur >= 6'h01 && s.seg_cur <= `SEG_MAX)
        else $error("segment index out of range");
    bus_answer_a: assert property (req |-> ##[0:1] !waitrequest)
        else $error("bus request not answered");
endmodule

// ==== rtl/pulse_train_defs.svh ====
// Offsets, field positions, reset values and rate limits of the pulse block
`ifndef PULSE_TRAIN_DEFS_SVH
`define PULSE_TRAIN_DEFS_SVH

// Register word indices; byte address is four times the index
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h01
`define OFS_POS0_LO 8'h02
`define OFS_POS0_HI 8'h03
`define OFS_POS1_LO 8'h04
`define OFS_POS1_HI 8'h05
`define OFS_TGT_X 8'h06
`define OFS_TGT_Y 8'h07
`define OFS_ARC_FREQ 8'h08
`define OFS_SEG_COUNT 8'h09
`define OFS_TABLE 8'h40

// Control bits
`define CTRL_ARC_RUN 0
`define CTRL_TAB_RUN 1
`define CTRL_CYCLIC 2
`define CTRL_TAB_CHAN 3

// Status bits
`define STAT_DONE 0
`define STAT_TAB_BUSY 1
`define STAT_ARC_BUSY 2
`define STAT_SEG_LSB 8

// Reset values
`define ARC_FREQ_RESET 32'h0000_0064
`define SEG_COUNT_RESET 6'h01

// Clock and output rate limits in Hz, then table segment limits
`define CLOCK_HZ 29'd250000000
`define FREQ_MIN_HZ 17'd6
`define FREQ_MAX_HZ 17'd100000
`define SEG_MAX 6'd40
`define WORDS_PER_SEG 4

`endif

// ==== rtl/pulse_train_pkg.sv ====
// Types of the pulse train block
package pulse_train_pkg;
    typedef struct packed {
        logic bus_wait;
        logic [31:0] rdata;
        logic arc_run;
        logic tab_run;
        logic cyclic;
        logic tab_chan;
        logic done;
        logic [1:0][31:0] pos;
        logic [1:0][31:0] tgt;
        logic [31:0] arc_freq;
        logic [5:0] seg_count;
        logic [5:0] seg_cap;
        logic [5:0] seg_cur;
        logic arc_act;
        logic arc_fin;
        logic tab_act;
        logic tab_fin;
        logic [16:0] tab_freq;
        logic [31:0] tab_left;
        logic [1:0] dir;
        logic [1:0] lvl;
        logic [1:0][28:0] acc;
    } pulse_state_t;
endpackage

// ==== test/drive_model.sv ====
// Pulse and direction drive that tracks its own position
`timescale 1ns/1ps

module drive_model
    import pulse_train_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Pulse and direction from the block
    input wire logic pulse,
    input wire logic dir,
    // Position seen by the drive
    output logic signed [31:0] steps
);
    logic last;

    ////////////////////////////////////////////////////////////////////////
    // One step per falling pulse edge; direction sampled one clock after that edge
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            last <= 1'b0;
            steps <= 32'sh0;
        end
        else
        begin
            last <= pulse;
            if (last && !pulse)
                steps <= dir ? steps - 1 : steps + 1;
        end
    end
endmodule

// ==== test/pulse_train_arc_and_table_output_test.sv ====
// Self-checking bench for the two-channel pulse train block
`timescale 1ns/1ps
`include "pulse_train_defs.svh"

module pulse_train_arc_and_table_output_test
    import pulse_train_pkg::*;
;
    logic clock, rst, read, write, waitrequest, first_channel_done_flag;
    logic x_pulse_out, x_direction_out, y_pulse_out, y_direction_out;
    logic [9:0] address;
    logic [31:0] writedata, readdata, rd, b, xb;
    logic signed [31:0] xs, ys;
    logic [15:0] tw [8];
    int failures, comparisons;

    pulse_train_arc_and_table_output dut_u (.clock(clock), .rst(rst),
        .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .x_pulse_out(x_pulse_out),
        .x_direction_out(x_direction_out), .y_pulse_out(y_pulse_out),
        .y_direction_out(y_direction_out),
        .first_channel_done_flag(first_channel_done_flag));
    drive_model x_drive_u (.clock(clock), .rst(rst), .pulse(x_pulse_out),
        .dir(x_direction_out), .steps(xs));
    drive_model y_drive_u (.clock(clock), .rst(rst), .pulse(y_pulse_out),
        .dir(y_direction_out), .steps(ys));

    always #2 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////
    // Avalon cycle: held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clock);
        address <= {a, 2'b00};
        write <= wr;
        read <= !wr;
        writedata <= d;
        @(posedge clock);
        while (waitrequest !== 1'b0)
            @(posedge clock);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask

    task automatic wait_done();
        int i;
        i = 0;
        while (first_channel_done_flag !== 1'b1 && i < 30000)
        begin
            @(posedge clock);
            i++;
        end
        // Drive model counts one edge after the pin falls
        @(posedge clock);
        chk("done flag", 32'h1, 32'(first_channel_done_flag));
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(1'b0, `OFS_POS0_LO, 32'h0);
        chk("pos0 low", 32'h0, rd);
        bus(1'b0, `OFS_ARC_FREQ, 32'h0);
        chk("arc freq", `ARC_FREQ_RESET, rd);
        bus(1'b0, `OFS_SEG_COUNT, 32'h0);
        chk("seg count", 32'(`SEG_COUNT_RESET), rd);
        bus(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask

    // X moves up three, Y down two from zero
    task automatic t_arc();
        bus(1'b1, `OFS_ARC_FREQ, 32'h0001_86A0);
        bus(1'b1, `OFS_TGT_X, 32'h3);
        bus(1'b1, `OFS_TGT_Y, 32'hFFFF_FFFE);
        bus(1'b1, `OFS_CTRL, 32'h1);
        repeat (3) @(posedge clock);
        chk("x dir", 32'h0, 32'(x_direction_out));
        chk("y dir", 32'h1, 32'(y_direction_out));
        wait_done();
        chk("x steps", 32'h3, xs);
        chk("y steps", 32'hFFFF_FFFE, ys);
        bus(1'b0, `OFS_POS0_LO, 32'h0);
        chk("pos0 low", 32'h3, rd);
        bus(1'b0, `OFS_POS1_LO, 32'h0);
        chk("pos1 low", 32'h0000_FFFE, rd);
        bus(1'b0, `OFS_POS1_HI, 32'h0);
        chk("pos1 high", 32'h0000_FFFF, rd);
        chk("y dir held", 32'h1, 32'(y_direction_out));
        bus(1'b1, `OFS_CTRL, 32'h0);
        repeat (3) @(posedge clock);
        chk("y dir off", 32'h0, 32'(y_direction_out));
    endtask

    // Two segments of two and one pulses; edits while busy must not land
    task automatic t_table();
        tw = '{16'h86A0, 16'h0001, 16'h0002, 16'h0000,
            16'h86A0, 16'h0001, 16'h0001, 16'h0000};
        bus(1'b1, `OFS_STATUS, 32'h1);
        for (int i = 0; i < 8; i++)
            bus(1'b1, `OFS_TABLE + 8'(i), 32'(tw[i]));
        bus(1'b1, `OFS_SEG_COUNT, 32'h2);
        b = xs;
        bus(1'b1, `OFS_CTRL, 32'h2);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk("segment", 32'h1, 32'(rd[13:8]));
        bus(1'b1, `OFS_TABLE + 8'h06, 32'h5);
        bus(1'b1, `OFS_SEG_COUNT, 32'h1);
        wait_done();
        chk("table steps", 32'h3, xs - b);
        chk("x dir table", 32'h0, 32'(x_direction_out));
    endtask

    // Cyclic run past one pass, then stop at once
    task automatic t_cyclic();
        int i;
        bus(1'b1, `OFS_CTRL, 32'h0);
        b = xs;
        bus(1'b1, `OFS_CTRL, 32'h6);
        i = 0;
        while (xs - b !== 32'sh5 && i < 40000)
        begin
            @(posedge clock);
            i++;
        end
        chk("cyclic steps", 32'h5, xs - b);
        bus(1'b1, `OFS_CTRL, 32'h0);
        repeat (2) @(posedge clock);
        chk("pulse stopped", 32'h0, 32'(x_pulse_out));
        b = xs;
        repeat (5000) @(posedge clock);
        chk("no more steps", 32'h0, xs - b);
    endtask

    // Table on the second channel: no done flag, X left alone
    task automatic t_table_y();
        int i;
        bus(1'b1, `OFS_STATUS, 32'h1);
        b = ys;
        xb = xs;
        bus(1'b1, `OFS_CTRL, 32'hA);
        i = 0;
        while (ys - b !== 32'h2 && i < 20000)
        begin
            @(posedge clock);
            i++;
        end
        repeat (3000) @(posedge clock);
        chk("y table steps", 32'h2, ys - b);
        chk("x untouched", xb, xs);
        chk("y dir table", 32'h0, 32'(y_direction_out));
        chk("done on y", 32'h0, 32'(first_channel_done_flag));
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk("table idle", 32'h0, 32'(rd[`STAT_TAB_BUSY]));
        bus(1'b1, `OFS_CTRL, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Scenarios need about 41k cycles; give up after 75k
    initial
    begin
        #300000;
        failures++;
        results();
    end

    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 10'h0;
        writedata = 32'h0;
        failures = 0;
        comparisons = 0;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        t_reset();
        t_arc();
        t_table();
        t_cyclic();
        t_table_y();
        results();
    end
endmodule
